/* File: hdl/epc_cmd.v */
// Purpose: parameter channel command interpreter of a motor encoder
// Assumes: 8N1 bytes on a half-duplex pair, frame ended by a line gap
// Notes: frame = address, command, arguments, xor checksum
`timescale 1ns/1ns
`default_nettype none
`include "epc_regs.vh"
module epc_cmd #(
  parameter [15:0] BIT_CYC = `EPC_BIT_CYC,
  parameter [19:0] GAP_CYC = `EPC_GAP_CYC,
  // Arbitrary identity values
  parameter [31:0] SERIAL_NO = 32'h0000_0001,
  parameter [15:0] FW_VER = 16'h0001
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Data pair seen as line levels
  input wire rs485_rx,
  output wire rs485_tx,
  output wire rs485_oe_n,
  // Fault events from the encoder core, one-cycle pulses
  input wire evt_speed,
  input wire evt_analog,
  input wire evt_txcur,
  input wire evt_wdog,
  input wire evt_table,
  input wire evt_i2c,
  input wire evt_limits,
  input wire evt_offset,
  // Held status
  output wire [7:0] last_status
);
  localparam S_RX = 3'b001;
  localparam S_EXEC = 3'b010;
  localparam S_TX = 3'b100;

  // Size of field f from the packed size vector
  function [5:0] fld_size;
    input [47:0] v;
    input [2:0] f;
    begin
      fld_size = v[f*6 +: 6];
    end
  endfunction

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg rx_s1_ff;
  reg rx_s2_ff;
  reg rx_act_ff;
  reg [15:0] rx_cnt_ff;
  reg [3:0] rx_bit_ff;
  reg [7:0] rx_sh_ff;
  reg [19:0] gap_ff;
  reg [7:0] rbuf_ff [0:7];
  reg [3:0] rcnt_ff;
  reg [7:0] rxor_ff;
  reg [7:0] key_ff;
  reg [7:0] made_ff;
  reg [7:0] wp_ff;
  reg [47:0] fsize_ff;
  reg [15:0] free_ff;
  reg [7:0] mem [0:255];
  reg [7:0] last_ff;
  reg [79:0] tx_frm_ff;
  reg [7:0] tx_chk_ff;
  reg [3:0] tx_n_ff;
  reg [9:0] tx_sh_ff;
  reg [3:0] tx_bit_ff;
  reg [15:0] tx_cnt_ff;
  reg tx_line_ff;
  reg oe_n_ff;

  wire [7:0] cmd = rbuf_ff[1];
  wire [2:0] fld = rbuf_ff[2][2:0];
  wire [7:0] waddr = rbuf_ff[3];
  wire [5:0] cur_sz = fld_size(fsize_ff, fld);
  wire [5:0] new_sz = rbuf_ff[3][5:0];
  // Fixed-size flag of the selected field
  wire [7:0] fix_mask = `EPC_FIX_MASK;
  wire fix_bit = fix_mask[fld];
  wire frame_end = (state_ff == S_RX) && !rx_act_ff && (rcnt_ff != 4'h0)
    && (gap_ff == GAP_CYC);
  wire addr_hit = (rbuf_ff[0] == `EPC_ADDR);

  assign rs485_tx = tx_line_ff;
  assign rs485_oe_n = oe_n_ff;
  assign last_status = last_ff;

  // Command decode and checks, in fixed priority order
  reg known;
  reg prot;
  reg [3:0] need;
  reg [7:0] code_b;
  reg [7:0] st;
  reg [3:0] plen;
  reg [47:0] pay;
  always @*
  begin
    known = 1'b1;
    prot = 1'b0;
    need = 4'h3;
    code_b = 8'h00;
    st = `EPC_S_OK;
    plen = 4'h0;
    pay = 48'h0;
    case (cmd)
      `EPC_C_STATUS, `EPC_C_SERIAL, `EPC_C_FREE: need = 4'h3;
      `EPC_C_FSTAT: need = 4'h4;
      `EPC_C_RDDATA: need = 4'h5;
      `EPC_C_KEY:
      begin
        need = 4'h5;
        prot = 1'b1;
        code_b = rbuf_ff[2];
      end
      `EPC_C_CREATE:
      begin
        need = 4'h6;
        prot = 1'b1;
        code_b = rbuf_ff[4];
      end
      `EPC_C_STORE:
      begin
        need = 4'h7;
        prot = 1'b1;
        code_b = rbuf_ff[5];
      end
      default: known = 1'b0;
    endcase
    if (rxor_ff != 8'h00)
      st = `EPC_S_CHK;
    else if (!known)
      st = `EPC_S_UNK;
    else if (rcnt_ff != need)
      st = `EPC_S_LEN;
    else if (prot && code_b != key_ff)
      st = `EPC_S_CODE;
    else
    begin
      case (cmd)
        `EPC_C_STATUS:
        begin
          plen = 4'h1;
          pay[47:40] = last_ff;
        end
        `EPC_C_SERIAL:
        begin
          plen = 4'h6;
          pay = {SERIAL_NO, FW_VER};
        end
        `EPC_C_FREE:
        begin
          plen = 4'h2;
          pay[47:32] = free_ff;
        end
        `EPC_C_KEY: plen = 4'h0;
        `EPC_C_FSTAT:
        begin
          if (rbuf_ff[2] >= `EPC_NFLD)
            st = `EPC_S_ARG;
          else if (!made_ff[fld])
            st = `EPC_S_NOFLD;
          else
          begin
            plen = 4'h2;
            pay[47:32] = {2'b00, cur_sz, 6'h00, fix_bit, wp_ff[fld]};
          end
        end
        `EPC_C_CREATE:
        begin
          if (rbuf_ff[2] >= `EPC_NFLD || new_sz == 6'h00 || new_sz > `EPC_FMAX)
            st = `EPC_S_ARG;
          else if (made_ff[fld] && fix_bit)
            st = `EPC_S_FIXED;
        end
        default:
        begin
          if (rbuf_ff[2] >= `EPC_NFLD)
            st = `EPC_S_ARG;
          else if (!made_ff[fld])
            st = `EPC_S_NOFLD;
          else if (cmd == `EPC_C_STORE && wp_ff[fld])
            st = `EPC_S_WPROT;
          else if (waddr >= {2'b00, cur_sz})
            st = `EPC_S_WADDR;
          else if (cmd == `EPC_C_RDDATA)
          begin
            plen = 4'h1;
            pay[47:40] = mem[{fld, waddr[4:0]}];
          end
        end
      endcase
    end
  end

  // Event code, highest priority first
  reg evt_any;
  reg [7:0] evt_code;
  always @*
  begin
    evt_any = 1'b1;
    evt_code = `EPC_S_OK;
    if (evt_wdog)
      evt_code = `EPC_S_WDOG;
    else if (evt_table)
      evt_code = `EPC_S_TABLE;
    else if (evt_i2c)
      evt_code = `EPC_S_I2C;
    else if (evt_limits)
      evt_code = `EPC_S_LIMITS;
    else if (evt_offset)
      evt_code = `EPC_S_OFFSET;
    else if (evt_txcur)
      evt_code = `EPC_S_TXCUR;
    else if (evt_analog)
      evt_code = `EPC_S_ANALOG;
    else if (evt_speed)
      evt_code = `EPC_S_SPEED;
    else
      evt_any = 1'b0;
  end

  // Sequencer; a frame for another station goes straight back to listening
  always @*
  begin
    case (state_ff)
      S_RX: nxt_state = (frame_end && addr_hit) ? S_EXEC : S_RX;
      S_EXEC: nxt_state = S_TX;
      S_TX: nxt_state = (tx_cnt_ff == 16'h0 && tx_bit_ff == 4'h0 && tx_n_ff == 4'h0)
        ? S_RX : S_TX;
      default: nxt_state = S_RX;
    endcase
  end

  // Receiver; own echo is ignored while we talk
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_act_ff <= 1'b0;
      rx_cnt_ff <= 16'h0;
      rx_bit_ff <= 4'h0;
      rx_sh_ff <= 8'h00;
      gap_ff <= 20'h0;
      rcnt_ff <= 4'h0;
      rxor_ff <= 8'h00;
    end
    else
    begin
      rx_s1_ff <= rs485_rx;
      rx_s2_ff <= rx_s1_ff;
      if (state_ff != S_RX || (frame_end && !addr_hit))
      begin
        rx_act_ff <= 1'b0;
        gap_ff <= 20'h0;
        rcnt_ff <= (state_ff == S_EXEC) ? rcnt_ff : 4'h0;
        rxor_ff <= (state_ff == S_EXEC) ? rxor_ff : 8'h00;
      end
      else if (!rx_act_ff)
      begin
        if (!rx_s2_ff)
        begin
          rx_act_ff <= 1'b1;
          rx_cnt_ff <= BIT_CYC >> 1;
          rx_bit_ff <= 4'h0;
        end
        if (rcnt_ff != 4'h0 && gap_ff != GAP_CYC)
          gap_ff <= gap_ff + 20'h1;
      end
      else if (rx_cnt_ff != 16'h0)
        rx_cnt_ff <= rx_cnt_ff - 16'h1;
      else
      begin
        rx_cnt_ff <= BIT_CYC - 16'h1;
        if (rx_bit_ff == 4'h0)
          rx_act_ff <= !rx_s2_ff; // Glitch on the start bit drops out here
        else if (rx_bit_ff != 4'h9)
          rx_sh_ff <= {rx_s2_ff, rx_sh_ff[7:1]};
        rx_bit_ff <= rx_bit_ff + 4'h1;
        if (rx_bit_ff == 4'h9)
        begin
          rx_act_ff <= 1'b0;
          gap_ff <= 20'h0;
          // Bad stop bit: the byte is lost and the checksum check catches it, or the length check if the lost byte was 00h
          if (rx_s2_ff)
          begin
            if (rcnt_ff < 4'h8)
              rbuf_ff[rcnt_ff[2:0]] <= rx_sh_ff;
            rcnt_ff <= (rcnt_ff == 4'hf) ? rcnt_ff : rcnt_ff + 4'h1;
            rxor_ff <= rxor_ff ^ rx_sh_ff;
          end
        end
      end
    end
  end

  // Command effects and held status; an event wins over a command error
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_ff <= S_RX;
      key_ff <= `EPC_KEY_RST;
      made_ff <= `EPC_MADE_RST;
      wp_ff <= `EPC_WP_RST;
      fsize_ff <= `EPC_FSIZE_RST;
      free_ff <= `EPC_FREE_RST;
      last_ff <= `EPC_S_OK;
    end
    else
    begin
      state_ff <= nxt_state;
      if (evt_any)
        last_ff <= evt_code;
      else if (state_ff == S_EXEC && st != `EPC_S_OK)
        last_ff <= st;
      if (state_ff == S_EXEC && st == `EPC_S_OK)
      begin
        if (cmd == `EPC_C_KEY)
          key_ff <= rbuf_ff[3];
        if (cmd == `EPC_C_STORE)
          mem[{fld, waddr[4:0]}] <= rbuf_ff[4];
        if (cmd == `EPC_C_CREATE)
        begin
          made_ff[fld] <= 1'b1;
          wp_ff[fld] <= rbuf_ff[3][7];
          fsize_ff[fld*6 +: 6] <= new_sz;
          free_ff <= free_ff + {10'h0, made_ff[fld] ? cur_sz : 6'h0} - {10'h0, new_sz};
        end
      end
    end
  end

  // Transmitter; the pair is driven only while a reply is going out
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      tx_frm_ff <= 80'h0;
      tx_chk_ff <= 8'h00;
      tx_n_ff <= 4'h0;
      tx_sh_ff <= 10'h3ff;
      tx_bit_ff <= 4'h0;
      tx_cnt_ff <= 16'h0;
      tx_line_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end
    else if (state_ff == S_EXEC)
    begin
      tx_frm_ff <= {`EPC_ADDR, cmd, st, pay, 8'h00};
      tx_chk_ff <= `EPC_ADDR ^ cmd ^ st ^ pay[47:40] ^ pay[39:32] ^ pay[31:24]
        ^ pay[23:16] ^ pay[15:8] ^ pay[7:0];
      tx_n_ff <= plen + 4'h4;
      tx_bit_ff <= 4'h0;
      tx_cnt_ff <= 16'h0;
      oe_n_ff <= 1'b0;
    end
    else if (state_ff == S_TX)
    begin
      if (tx_cnt_ff != 16'h0)
        tx_cnt_ff <= tx_cnt_ff - 16'h1;
      else if (tx_bit_ff != 4'h0)
      begin
        tx_line_ff <= tx_sh_ff[0];
        tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
        tx_bit_ff <= tx_bit_ff - 4'h1;
        tx_cnt_ff <= BIT_CYC - 16'h1;
      end
      else if (tx_n_ff != 4'h0)
      begin
        tx_sh_ff <= {1'b1, (tx_n_ff == 4'h1) ? tx_chk_ff : tx_frm_ff[79:72], 1'b0};
        tx_frm_ff <= {tx_frm_ff[71:0], 8'h00};
        tx_n_ff <= tx_n_ff - 4'h1;
        tx_bit_ff <= 4'ha;
      end
      else
      begin
        tx_line_ff <= 1'b1;
        oe_n_ff <= 1'b1;
      end
    end
  end
endmodule // epc_cmd
`default_nettype wire

/* File: pkg/epc_regs.vh */
// Purpose: constants of the encoder parameter channel command block
// Assumes: included by its bare name
// Notes: definitions only
`ifndef EPC_REGS_VH
`define EPC_REGS_VH
// Station and key
`define EPC_ADDR 8'h40
`define EPC_KEY_RST 8'h55
// Link timing: clocks per bit, and the idle gap that ends a frame
`define EPC_BIT_CYC 16'h1458
`define EPC_GAP_CYC 20'h196e0
// Command bytes
`define EPC_C_RDDATA 8'h4a
`define EPC_C_STORE 8'h4b
`define EPC_C_FSTAT 8'h4c
`define EPC_C_CREATE 8'h4d
`define EPC_C_FREE 8'h4e
`define EPC_C_KEY 8'h4f
`define EPC_C_STATUS 8'h50
`define EPC_C_SERIAL 8'h56
// Status codes
`define EPC_S_OK 8'h00
`define EPC_S_OFFSET 8'h02
`define EPC_S_TABLE 8'h03
`define EPC_S_LIMITS 8'h04
`define EPC_S_I2C 8'h05
`define EPC_S_WDOG 8'h07
`define EPC_S_CHK 8'h0a
`define EPC_S_UNK 8'h0b
`define EPC_S_LEN 8'h0c
`define EPC_S_ARG 8'h0d
`define EPC_S_WPROT 8'h0e
`define EPC_S_CODE 8'h0f
`define EPC_S_FIXED 8'h10
`define EPC_S_WADDR 8'h11
`define EPC_S_NOFLD 8'h12
`define EPC_S_ANALOG 8'h1c
`define EPC_S_TXCUR 8'h1d
`define EPC_S_SPEED 8'h1f
// Data fields: eight fields of up to 32 words
`define EPC_NFLD 8'h08
`define EPC_FMAX 6'h20
`define EPC_MADE_RST 8'h81
`define EPC_WP_RST 8'h80
`define EPC_FIX_MASK 8'h81
`define EPC_FSIZE_RST 48'h800000000020
`define EPC_MEM_BYTES 16'h0700
`define EPC_FREE_RST 16'h06c0
`endif

/* File: testbench/epc_asserts.sv */
// Purpose: port checks of the command block
// Assumes: one clock, synchronous reset
// Notes: bound onto epc_cmd
`timescale 1ns/1ns
`default_nettype none
module epc_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Pair driver
  input wire logic rs485_tx,
  input wire logic rs485_oe_n,
  // Fault events
  input wire logic evt_speed,
  input wire logic evt_analog,
  input wire logic evt_txcur,
  input wire logic evt_wdog,
  input wire logic evt_table,
  input wire logic evt_i2c,
  input wire logic evt_limits,
  input wire logic evt_offset,
  // Held status
  input wire logic [7:0] last_status
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // Faults that outrank the lower ones in the same cycle
  wire logic hi_four = evt_wdog | evt_table | evt_i2c | evt_limits;
  wire logic above_spd = hi_four | evt_offset | evt_txcur | evt_analog;
  // Reset result and idle line
  a_reset_clear: assert property (disable iff (1'b0) reset |=> last_status == 8'h00)
    else $error("status not clear");
  a_idle_high: assert property (rs485_oe_n |-> rs485_tx)
    else $error("line not idle");
  // Reply framing on the pair
  a_start_soon: assert property ($fell(rs485_oe_n) |-> ##[1:3] !rs485_tx)
    else $error("no start bit");
  a_drive_hold: assert property ($fell(rs485_oe_n) |=> !rs485_oe_n [*8])
    else $error("driver dropped");
  // Fault events reach the held status; watchdog wins a tie
  a_wdog_code: assert property (evt_wdog |-> ##[1:2] last_status == 8'h07)
    else $error("no 07h");
  a_fast_code: assert property (evt_speed & !above_spd |-> ##[1:2] last_status==8'h1f)
    else $error("no 1fh");
  a_table_code: assert property (evt_table & !evt_wdog |-> ##[1:2] last_status == 8'h03)
    else $error("no 03h");
  a_offset_code: assert property (evt_offset & !hi_four |-> ##[1:2] last_status == 8'h02)
    else $error("no 02h");
endmodule // epc_asserts
bind epc_cmd epc_asserts i_chk (.ref_clk, .reset, .rs485_tx, .rs485_oe_n, .evt_speed,
  .evt_analog, .evt_txcur, .evt_wdog, .evt_table, .evt_i2c, .evt_limits, .evt_offset,
  .last_status);
`default_nettype wire

/* File: testbench/epc_host.sv */
// Purpose: drive controller model on the pair
// Assumes: 8N1 bytes, LSB first
// Notes: checksum appended, its LSB flipped when bad is set
`timescale 1ns/1ns
`default_nettype none
module epc_host #(
  parameter int BIT = 8
) (
  // Clock
  input wire logic ref_clk,
  // Encoder driver side
  input wire logic rs485_tx,
  input wire logic rs485_oe_n,
  // Resolved pair level
  output logic line
);
  logic drv_ff = 1'b1;
  logic [7:0] q [0:15];
  int rx_n;
  int gap_bits = 0;
  int bad = 0;
  // One shared pair, owned by whoever is enabled
  assign line = rs485_oe_n ? drv_ff : rs485_tx;
  // Start, data LSB first, stop, then idle bits for a slow sender
  task automatic put(input logic [7:0] b);
    int i;
    drv_ff <= 1'b0;
    repeat (BIT) @(posedge ref_clk);
    for (i = 0; i < 8; i++)
    begin
      drv_ff <= b[i];
      repeat (BIT) @(posedge ref_clk);
    end
    drv_ff <= 1'b1;
    repeat (BIT * (gap_bits + 1)) @(posedge ref_clk);
  endtask
  // Frame of n bytes, the key byte passed through as given
  task automatic send(input logic [63:0] v, input int n);
    int k;
    logic [7:0] c;
    c = 8'h00;
    @(posedge ref_clk);
    for (k = n - 2; k >= 0; k--)
    begin
      c ^= v[8*k+:8];
      put(v[8*k+:8]);
    end
    put(c ^ 8'(bad));
  endtask
  // Collect reply bytes while the encoder drives
  task automatic get_reply();
    int t;
    int i;
    rx_n = 0;
    t = 0;
    while (rs485_oe_n && t < 1000)
    begin
      @(posedge ref_clk);
      t++;
    end
    while (!rs485_oe_n)
    begin
      @(posedge ref_clk);
      if (!line && rx_n < 16)
      begin
        repeat (BIT / 2) @(posedge ref_clk);
        for (i = 0; i < 8; i++)
        begin
          repeat (BIT) @(posedge ref_clk);
          q[rx_n][i] = line;
        end
        repeat (BIT) @(posedge ref_clk);
        rx_n++;
      end
    end
  endtask
endmodule // epc_host
`default_nettype wire

/* File: testbench/encoder_param_channel_commands_test.sv */
// Purpose: self-checking bench of the command block
// Assumes: short bit and gap counts
// Notes: scenarios run in order
`timescale 1ns/1ns
`default_nettype none
module encoder_param_channel_commands_test;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] evt = 8'h00;
  wire logic rs485_rx;
  wire logic rs485_tx;
  wire logic rs485_oe_n;
  wire logic [7:0] last_status;
  int mismatches = 0;
  int total_checks = 0;
  // 50 MHz
  always #10 ref_clk = ~ref_clk;
  // Short counts keep frames brief
  epc_cmd #(.BIT_CYC(16'h0008), .GAP_CYC(20'h000c8), .SERIAL_NO(32'h1234_5678),
    .FW_VER(16'h0102)) i_dut (.ref_clk, .reset, .rs485_rx, .rs485_tx, .rs485_oe_n,
    .evt_speed(evt[0]), .evt_analog(evt[1]), .evt_txcur(evt[2]), .evt_wdog(evt[3]),
    .evt_table(evt[4]), .evt_i2c(evt[5]), .evt_limits(evt[6]), .evt_offset(evt[7]),
    .last_status);
  epc_host i_host (.ref_clk, .rs485_tx, .rs485_oe_n, .line(rs485_rx));
  // Byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // Request, then reply header, status, size and checksum
  task automatic ask(input logic [63:0] v, input int n, input logic [7:0] st, input int np);
    int k;
    logic [7:0] x;
    x = 8'h00;
    i_host.send(v, n);
    i_host.get_reply();
    chk(8'(i_host.rx_n), 8'(np + 4));
    chk(i_host.q[0], 8'h40);
    chk(i_host.q[1], v[8*(n-3)+:8]);
    chk(i_host.q[2], st);
    for (k = 0; k < i_host.rx_n; k++)
      x ^= i_host.q[k];
    chk(x, 8'h00);
  endtask
  // Idle pair and clear status
  task automatic t_reset();
    chk(last_status, 8'h00);
    chk({7'h00, rs485_oe_n}, 8'h01);
    chk({7'h00, rs485_tx}, 8'h01);
  endtask
  // Status, identity and free memory
  task automatic t_reads();
    int k;
    logic [47:0] id;
    id = 48'h1234_5678_0102;
    ask(64'h4050, 3, 8'h00, 1);
    chk(i_host.q[3], 8'h00);
    ask(64'h4056, 3, 8'h00, 6);
    for (k = 0; k < 6; k++)
      chk(i_host.q[3+k], id[8*(5-k)+:8]);
    ask(64'h404e, 3, 8'h00, 2);
    chk(i_host.q[3], 8'h06);
    chk(i_host.q[4], 8'hc0);
  endtask
  // Preset, missing and out-of-range fields
  task automatic t_fields();
    ask(64'h404c07, 4, 8'h00, 2);
    chk(i_host.q[3], 8'h20);
    chk(i_host.q[4], 8'h03);
    ask(64'h404c03, 4, 8'h12, 0);
    ask(64'h404c08, 4, 8'h0d, 0);
  endtask
  // Frame and command faults from a slow sender; last error held
  task automatic t_errors();
    i_host.gap_bits = 2;
    i_host.bad = 1;
    ask(64'h4050, 3, 8'h0a, 0);
    i_host.bad = 0;
    ask(64'h4051, 3, 8'h0b, 0);
    ask(64'h405000, 4, 8'h0c, 0);
    ask(64'h404b07005a55, 7, 8'h0e, 0);
    ask(64'h404d000455, 6, 8'h10, 0);
    ask(64'h404a0020, 5, 8'h11, 0);
    chk(last_status, 8'h11);
    i_host.gap_bits = 0;
    ask(64'h4050, 3, 8'h00, 1);
    chk(i_host.q[3], 8'h11);
  endtask
  // Key change, keyed store and read back, memory use
  task automatic t_key();
    ask(64'h404b00013c99, 7, 8'h0f, 0);
    ask(64'h404f55aa, 5, 8'h00, 0);
    ask(64'h404b00013c55, 7, 8'h0f, 0);
    ask(64'h404b00013caa, 7, 8'h00, 0);
    ask(64'h404a0001, 5, 8'h00, 1);
    chk(i_host.q[3], 8'h3c);
    ask(64'h404d0300aa, 6, 8'h0d, 0);
    ask(64'h404d0304aa, 6, 8'h00, 0);
    ask(64'h404e, 3, 8'h00, 2);
    chk(i_host.q[3], 8'h06);
    chk(i_host.q[4], 8'hbc);
  endtask
  // Another station's frame gets no answer
  task automatic t_foreign();
    int t;
    logic low;
    low = 1'b0;
    i_host.send(64'h4150, 3);
    for (t = 0; t < 300; t++)
    begin
      @(posedge ref_clk);
      low = low | !rs485_oe_n;
    end
    chk({7'h00, low}, 8'h00);
    ask(64'h4050, 3, 8'h00, 1);
  endtask
  // One-cycle fault pulse, then settle
  task automatic pulse(input logic [7:0] m);
    evt <= m;
    @(posedge ref_clk);
    evt <= 8'h00;
    repeat (3) @(posedge ref_clk);
  endtask
  // Every fault code, and watchdog winning a tie
  task automatic t_events();
    int i;
    logic [63:0] c;
    c = 64'h0204_0503_071d_1c1f;
    @(posedge ref_clk);
    for (i = 0; i < 4; i++)
    begin
      pulse(8'h01 << i);
      chk(last_status, c[8*i+:8]);
      pulse(8'h10 << i);
      chk(last_status, c[8*i+32+:8]);
    end
    pulse(8'h09);
    chk(last_status, 8'h07);
  endtask
  // Mid-run reset brings back the delivery key, drops created fields and clears status
  task automatic t_rekey();
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(last_status, 8'h00);
    ask(64'h404c03, 4, 8'h12, 0);
    ask(64'h404f55aa, 5, 8'h00, 0);
  endtask
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog well above the expected run
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    complete_run();
  end
  // Reset, then the scenarios
  initial
  begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_reads();
    t_fields();
    t_errors();
    t_key();
    t_foreign();
    t_events();
    t_rekey();
    complete_run();
  end
endmodule // encoder_param_channel_commands_test
`default_nettype wire
